// ---- core/mcsr_pkg.sv ----
// Constants and carrier types for the core special register block.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package mcsr_pkg;

    // APB address width; register byte address is four times the index.
    localparam int unsigned MCSR_ADDR_W = 10;

    // Register indices, as printed; byte address = index * 4.
    localparam logic [7:0] MCSR_IDX_SP    = 8'h81;
    localparam logic [7:0] MCSR_IDX_DPL0  = 8'h82;
    localparam logic [7:0] MCSR_IDX_DPH0  = 8'h83;
    localparam logic [7:0] MCSR_IDX_SECOND_PTR_LOW  = 8'h84;
    localparam logic [7:0] MCSR_IDX_SECOND_PTR_HIGH  = 8'h85;
    localparam logic [7:0] MCSR_IDX_CTRL  = 8'h87;
    localparam logic [7:0] MCSR_IDX_DPS   = 8'h92;
    localparam logic [7:0] MCSR_IDX_PAGED_DATA_UPPER_ADDR = 8'hc9;
    localparam logic [7:0] MCSR_IDX_PSW   = 8'hd0;
    localparam logic [7:0] MCSR_IDX_ACC   = 8'he0;
    localparam logic [7:0] MCSR_IDX_B     = 8'hf0;

    // Reset values.
    localparam logic [7:0]  MCSR_RST_BYTE  = 8'h00;
    localparam logic [7:0]  MCSR_RST_SP    = 8'h00;
    localparam logic [7:0]  MCSR_RST_PAGED_DATA_UPPER_ADDR = 8'h00;
    localparam logic [15:0] MCSR_RST_ACTIVE_DATA_POINTER  = 16'h0000;

    // Status word field positions.
    localparam int unsigned MCSR_PSW_CY  = 7;
    localparam int unsigned MCSR_PSW_AC  = 6;
    localparam int unsigned MCSR_PSW_F0  = 5;
    localparam int unsigned MCSR_PSW_RSH = 4;
    localparam int unsigned MCSR_PSW_RSL = 3;
    localparam int unsigned MCSR_PSW_OV  = 2;
    localparam int unsigned MCSR_PSW_F1  = 1;

    // Control register field positions; bits 1:0 always read zero.
    localparam int unsigned MCSR_CTL_BAUD = 7;
    localparam int unsigned MCSR_CTL_CWM  = 4;
    localparam logic [7:0]  MCSR_CTL_MASK = 8'hfc;
    localparam logic [7:0]  MCSR_DPS_MASK = 8'h01;

    // Hardware updates from the instruction core, same clock.
    typedef struct packed {
        logic        acc_we;
        logic [7:0]  acc;
        logic        b_we;
        logic [7:0]  b;
        logic        cy_we;
        logic        cy;
        logic        ac_we;
        logic        ac;
        logic        ov_we;
        logic        ov;
        logic        sp_push;
        logic        sp_pop;
        logic        dp_we;
        logic [15:0] dp;
    } mcsr_core_s;

endpackage

// ---- core/mcsr_core_regs.sv ----
// Core special registers: operand registers, status word, stack top,
// dual data pointers, paged-data page and control, behind an APB slave.
// Assumes the instruction core sits on the same clock as the APB bus.
`timescale 1ns/1ns
module mcsr_core_regs
    import mcsr_pkg::*;
(
    // Clock, reset and freeze.
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_nrst,
    input  wire logic                   i_ce,
    // APB slave.
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [MCSR_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]            i_pwdata,
    input  wire logic [3:0]             i_pstrb,
    output logic      [31:0]            o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    // Instruction core side.
    input  mcsr_core_s                  i_core,
    input  wire logic [7:0]             i_ri_val,
    input  wire logic [2:0]             i_reg_sel,
    // Register views and derived addresses.
    output logic      [7:0]             o_acc,
    output logic      [7:0]             o_b,
    output logic      [7:0]             o_psw,
    output logic      [7:0]             o_sp,
    output logic      [7:0]             o_stack_addr,
    output logic      [15:0]            o_active_data_pointer,
    output logic      [15:0]            o_paged_data_access_addr,
    output logic      [4:0]             o_reg_addr,
    output logic                        o_code_write_mode,
    output logic                        o_baud_doubler
);

    // Storage.
    logic [7:0]  acc_ff;
    logic [7:0]  b_ff;
    logic        par_ff;
    logic [7:1]  psw_ff;
    logic [7:0]  sp_ff;
    logic [15:0] dp0_ff;
    logic [15:0] dp1_ff;
    logic        dps_ff;
    logic [7:0]  ctl_ff;
    logic [7:0]  paged_data_upper_addr_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;

    // Next values.
    logic [7:0]  nxt_acc;
    logic [7:0]  nxt_b;
    logic [7:1]  nxt_psw;
    logic [7:0]  nxt_sp;
    logic [15:0] nxt_dp0;
    logic [15:0] nxt_dp1;

    // Bus decode.
    logic [7:0]  idx;
    logic        aligned;
    logic        setup;
    logic        wr_acc;
    logic        hit_sp;
    logic        hit_dpl0;
    logic        hit_dph0;
    logic        hit_second_ptr_low;
    logic        hit_second_ptr_high;
    logic        hit_ctl;
    logic        hit_dps;
    logic        hit_paged_data_upper_addr;
    logic        hit_psw;
    logic        hit_acc;
    logic        hit_b;
    logic        mapped;
    logic        wr_ok;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic [7:0]  psw_view;

    assign idx      = i_paddr[9:2];
    assign aligned  = (i_paddr[1:0] == 2'h0);
    assign setup    = i_psel & ~i_penable;
    assign wr_acc   = i_psel & i_penable & i_pwrite & ~pslverr_ff;
    assign wbyte    = i_pwdata[7:0];

    assign hit_sp    = aligned & (idx == MCSR_IDX_SP);
    assign hit_dpl0  = aligned & (idx == MCSR_IDX_DPL0);
    assign hit_dph0  = aligned & (idx == MCSR_IDX_DPH0);
    assign hit_second_ptr_low  = aligned & (idx == MCSR_IDX_SECOND_PTR_LOW);
    assign hit_second_ptr_high  = aligned & (idx == MCSR_IDX_SECOND_PTR_HIGH);
    assign hit_ctl   = aligned & (idx == MCSR_IDX_CTRL);
    assign hit_dps   = aligned & (idx == MCSR_IDX_DPS);
    assign hit_paged_data_upper_addr = aligned & (idx == MCSR_IDX_PAGED_DATA_UPPER_ADDR);
    assign hit_psw   = aligned & (idx == MCSR_IDX_PSW);
    assign hit_acc   = aligned & (idx == MCSR_IDX_ACC);
    assign hit_b     = aligned & (idx == MCSR_IDX_B);

    assign mapped = hit_sp | hit_dpl0 | hit_dph0 | hit_second_ptr_low | hit_second_ptr_high
                  | hit_ctl | hit_dps | hit_paged_data_upper_addr | hit_psw | hit_acc
                  | hit_b;

    // A write without lane 0 enabled stores nothing but is not an error.
    assign wr_ok = wr_acc & i_pstrb[0];

    // Parity lives in its own flop so the status view stays registered.
    assign psw_view = {psw_ff, par_ff};

    assign rbyte =
          hit_sp    ? sp_ff
        : hit_dpl0  ? dp0_ff[7:0]
        : hit_dph0  ? dp0_ff[15:8]
        : hit_second_ptr_low  ? dp1_ff[7:0]
        : hit_second_ptr_high  ? dp1_ff[15:8]
        : hit_ctl   ? (ctl_ff & MCSR_CTL_MASK)
        : hit_dps   ? {7'h00, dps_ff}
        : hit_paged_data_upper_addr ? paged_data_upper_addr_ff
        : hit_psw   ? psw_view
        : hit_acc   ? acc_ff
        : hit_b     ? b_ff
        : 8'h00;

    // Core updates win over a bus write in the same cycle, because the
    // core owns instruction results and must never lose one.
    always_comb begin
        nxt_acc = acc_ff;
        if (i_core.acc_we) begin
            nxt_acc = i_core.acc;
        end else if (wr_ok && hit_acc) begin
            nxt_acc = wbyte;
        end
    end

    always_comb begin
        nxt_b = b_ff;
        if (i_core.b_we) begin
            nxt_b = i_core.b;
        end else if (wr_ok && hit_b) begin
            nxt_b = wbyte;
        end
    end

    always_comb begin
        nxt_psw = psw_ff;
        if (wr_ok && hit_psw) begin
            nxt_psw = wbyte[7:1];
        end
        if (i_core.cy_we) begin
            nxt_psw[MCSR_PSW_CY] = i_core.cy;
        end
        if (i_core.ac_we) begin
            nxt_psw[MCSR_PSW_AC] = i_core.ac;
        end
        if (i_core.ov_we) begin
            nxt_psw[MCSR_PSW_OV] = i_core.ov;
        end
    end

    // A push bumps the pointer first, so the store lands at sp+1 and the
    // pointer then names the newest byte; a pop reads at sp then drops.
    always_comb begin
        nxt_sp = sp_ff;
        if (i_core.sp_push && !i_core.sp_pop) begin
            nxt_sp = sp_ff + 8'h01;
        end else if (i_core.sp_pop && !i_core.sp_push) begin
            nxt_sp = sp_ff - 8'h01;
        end else if (wr_ok && hit_sp) begin
            nxt_sp = wbyte;
        end
    end

    // Only the selected pointer takes 16-bit core loads.
    always_comb begin
        nxt_dp0 = dp0_ff;
        if (i_core.dp_we && !dps_ff) begin
            nxt_dp0 = i_core.dp;
        end else if (wr_ok && hit_dpl0) begin
            nxt_dp0[7:0] = wbyte;
        end else if (wr_ok && hit_dph0) begin
            nxt_dp0[15:8] = wbyte;
        end
    end

    always_comb begin
        nxt_dp1 = dp1_ff;
        if (i_core.dp_we && dps_ff) begin
            nxt_dp1 = i_core.dp;
        end else if (wr_ok && hit_second_ptr_low) begin
            nxt_dp1[7:0] = wbyte;
        end else if (wr_ok && hit_second_ptr_high) begin
            nxt_dp1[15:8] = wbyte;
        end
    end

    // Operand registers and status word.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_ff <= MCSR_RST_BYTE;
            b_ff   <= MCSR_RST_BYTE;
            par_ff <= 1'b0;
            psw_ff <= 7'h00;
        end else if (i_ce) begin
            acc_ff <= nxt_acc;
            b_ff   <= nxt_b;
            par_ff <= ^nxt_acc;
            psw_ff <= nxt_psw;
        end
    end

    // Stack top and data pointers.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            sp_ff  <= MCSR_RST_SP;
            dp0_ff <= MCSR_RST_ACTIVE_DATA_POINTER;
            dp1_ff <= MCSR_RST_ACTIVE_DATA_POINTER;
        end else if (i_ce) begin
            sp_ff  <= nxt_sp;
            dp0_ff <= nxt_dp0;
            dp1_ff <= nxt_dp1;
        end
    end

    // Software-only control registers.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            dps_ff   <= 1'b0;
            ctl_ff   <= MCSR_RST_BYTE;
            paged_data_upper_addr_ff <= MCSR_RST_PAGED_DATA_UPPER_ADDR;
        end else if (i_ce && wr_ok) begin
            if (hit_dps) begin
                dps_ff <= wbyte[0];
            end
            if (hit_ctl) begin
                ctl_ff <= wbyte & MCSR_CTL_MASK;
            end
            if (hit_paged_data_upper_addr) begin
                paged_data_upper_addr_ff <= wbyte;
            end
        end
    end

    // Read data and error are captured in the setup phase so the access
    // phase can answer at once from flops; a core update landing in that
    // one setup cycle is seen by the next read, not this one.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (i_ce && setup) begin
            prdata_ff  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rbyte};
            pslverr_ff <= ~mapped;
        end
    end

    // Bus answers.
    assign o_prdata  = prdata_ff;
    assign o_pready  = i_psel & i_penable & i_ce;
    assign o_pslverr = i_psel & i_penable & pslverr_ff;

    // Register views.
    assign o_acc = acc_ff;
    assign o_b   = b_ff;
    assign o_psw = psw_view;
    assign o_sp  = sp_ff;

    // Push address is the incremented pointer; pop reads at the pointer.
    assign o_stack_addr = i_core.sp_push ? (sp_ff + 8'h01) : sp_ff;

    assign o_active_data_pointer = dps_ff ? dp1_ff : dp0_ff;

    // Page byte on top, R0/R1 content below: one 256-byte page.
    assign o_paged_data_access_addr = {paged_data_upper_addr_ff, i_ri_val};

    // Bank bits pick one eight-byte group in the lowest 32 RAM bytes.
    assign o_reg_addr = {psw_ff[MCSR_PSW_RSH:MCSR_PSW_RSL], i_reg_sel};

    assign o_code_write_mode = ctl_ff[MCSR_CTL_CWM];
    assign o_baud_doubler    = ctl_ff[MCSR_CTL_BAUD];

endmodule

// ---- verification/mcsr_core_regs_props.sv ----
// Concurrent checks for the core special register block.
// Assumes it is bound to mcsr_core_regs and sees only its ports.
`timescale 1ns/1ns
module mcsr_core_regs_props
    import mcsr_pkg::*;
(
    // Clock, reset and freeze.
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        i_ce,
    // Core side.
    input  mcsr_core_s       i_core,
    input  wire logic [2:0]  i_reg_sel,
    // Register views.
    input  wire logic [7:0]  o_acc,
    input  wire logic [7:0]  o_b,
    input  wire logic [7:0]  o_psw,
    input  wire logic [7:0]  o_sp,
    input  wire logic [7:0]  o_stack_addr,
    input  wire logic [15:0] o_active_data_pointer,
    input  wire logic [4:0]  o_reg_addr
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    chk_parity_odd: assert property (o_psw[0] == ^o_acc)
        else $error("parity bit wrong");
    chk_bank_addr: assert property (
        o_reg_addr == {o_psw[4:3], i_reg_sel}) else $error("bank wrong");
    chk_push_incr: assert property (
        i_ce && i_core.sp_push && !i_core.sp_pop |->
        o_stack_addr == o_sp + 8'h01 ##1 o_sp == $past(o_sp) + 8'h01)
        else $error("push wrong");
    chk_pop_decr: assert property (
        i_ce && i_core.sp_pop && !i_core.sp_push |=>
        o_sp == $past(o_sp) - 8'h01) else $error("pop wrong");
    chk_active_data_pointer_load: assert property (
        i_ce && i_core.dp_we |=> o_active_data_pointer == $past(i_core.dp))
        else $error("pointer load wrong");
    chk_acc_load: assert property (
        i_ce && i_core.acc_we |=> o_acc == $past(i_core.acc))
        else $error("operand load wrong");
    chk_aux_load: assert property (
        i_ce && i_core.b_we |=> o_b == $past(i_core.b))
        else $error("aux load wrong");
    chk_carry_load: assert property (
        i_ce && i_core.cy_we |=> o_psw[7] == $past(i_core.cy))
        else $error("carry load wrong");

    cover property (i_ce && i_core.sp_push);
    cover property (i_ce && i_core.sp_pop);
    cover property (i_ce && i_core.dp_we);
    cover property (!i_ce && i_core.acc_we);
endmodule

bind mcsr_core_regs mcsr_core_regs_props u_props (
    .i_clk_sys, .i_nrst, .i_ce, .i_core, .i_reg_sel, .o_acc, .o_b,
    .o_psw, .o_sp, .o_stack_addr, .o_active_data_pointer, .o_reg_addr
);

// ---- verification/mcsr_core_regs_tb.sv ----
// Self-checking bench for the core special register block.
// Assumes zero-wait APB answers; the bench drives the core side.
`timescale 1ns/1ns
module mcsr_core_regs_tb import mcsr_pkg::*;;
    logic                   i_clk_sys, i_nrst, i_ce;
    logic                   i_psel, i_penable, i_pwrite;
    logic [MCSR_ADDR_W-1:0] i_paddr;
    logic [31:0]            i_pwdata, o_prdata, rd;
    logic [3:0]             i_pstrb;
    logic                   o_pready, o_pslverr, er;
    mcsr_core_s             i_core, c;
    logic [7:0]             i_ri_val, o_acc, o_b, o_psw, o_sp;
    logic [7:0]             o_stack_addr, v;
    logic [2:0]             i_reg_sel;
    logic [15:0]            o_active_data_pointer, o_paged_data_access_addr;
    logic [4:0]             o_reg_addr;
    logic                   o_code_write_mode, o_baud_doubler;
    int                     fail_count, checks;
    logic [7:0]             idx [11];

    mcsr_core_regs uut (
        .i_clk_sys, .i_nrst, .i_ce, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr,
        .i_core, .i_ri_val, .i_reg_sel, .o_acc, .o_b, .o_psw, .o_sp,
        .o_stack_addr, .o_active_data_pointer, .o_paged_data_access_addr, .o_reg_addr,
        .o_code_write_mode, .o_baud_doubler
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask

    // Holds the request until pready is seen, then releases it.
    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge i_clk_sys);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= w;
        i_paddr   <= {a, 2'b00};
        i_pwdata  <= {24'h000000, d};
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        #1;
    endtask

    task automatic rdc(input logic [7:0] a, e, input string n);
        apb(1'b0, a, 8'h00);
        chk(n, rd, {24'h000000, e});
    endtask

    task automatic pulse(input mcsr_core_s p);
        @(posedge i_clk_sys);
        i_core <= p;
        @(posedge i_clk_sys);
        i_core <= '0;
        #1;
    endtask

    task automatic t_regs();
        foreach (idx[k]) rdc(idx[k], 8'h00, "reset");
        for (int k = 1; k < 11; k++) begin
            v = 8'h3c ^ idx[k];
            apb(1'b1, idx[k], v);
            rdc(idx[k], v & (k == 6 ? 8'h01 : k == 5 ? 8'hfc :
                k == 8 ? 8'hfe : 8'hff), "rw");
        end
        apb(1'b0, 8'h86, 8'h00);
        chk("unmapped err", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
    endtask

    task automatic t_ctrl();
        apb(1'b1, MCSR_IDX_CTRL, 8'hff);
        rdc(MCSR_IDX_CTRL, 8'hfc, "ctrl low");
        chk("cwm", o_code_write_mode, 1'b1);
        chk("baud", o_baud_doubler, 1'b1);
        apb(1'b1, MCSR_IDX_CTRL, 8'h6c);
        rdc(MCSR_IDX_CTRL, 8'h6c, "ctrl flags");
        chk("cwm off", o_code_write_mode, 1'b0);
        chk("baud off", o_baud_doubler, 1'b0);
    endtask

    task automatic t_addr();
        apb(1'b1, MCSR_IDX_PAGED_DATA_UPPER_ADDR, 8'h80);
        @(posedge i_clk_sys);
        i_ri_val <= 8'h34;
        #1;
        chk("page addr", o_paged_data_access_addr, 16'h8034);
        for (int b = 0; b < 4; b++) begin
            v = {2'b00, 1'b1, 2'(b), 3'b010};
            apb(1'b1, MCSR_IDX_PSW, v);
            i_reg_sel <= 3'(7 - b);
            rdc(MCSR_IDX_PSW, v | 8'h01, "user flags");
            chk("bank", o_reg_addr, {2'(b), 3'(7 - b)});
        end
    endtask

    // Pointer one is left holding 8'hb9 and 8'hb8 by t_regs.
    task automatic t_active_data_pointer();
        apb(1'b1, MCSR_IDX_DPS, 8'hfe);
        apb(1'b1, MCSR_IDX_DPL0, 8'h21);
        apb(1'b1, MCSR_IDX_DPH0, 8'h43);
        chk("ptr zero", o_active_data_pointer, 16'h4321);
        apb(1'b1, MCSR_IDX_DPS, 8'h01);
        chk("ptr one", o_active_data_pointer, 16'hb9b8);
        apb(1'b1, MCSR_IDX_SECOND_PTR_LOW, 8'h77);
        chk("half", o_active_data_pointer, 16'hb977);
        c = '0;
        c.dp_we = 1'b1;
        c.dp = 16'hbeef;
        pulse(c);
        rdc(MCSR_IDX_SECOND_PTR_HIGH, 8'hbe, "ptr load");
        rdc(MCSR_IDX_DPL0, 8'h21, "ptr kept");
    endtask

    task automatic t_core();
        c = '{acc_we: 1, acc: 8'h07, b_we: 1, b: 8'h99, cy_we: 1, cy: 1,
              ac_we: 1, ac: 1, ov_we: 1, ov: 1, default: '0};
        pulse(c);
        chk("acc", o_acc, 8'h07);
        chk("aux", o_b, 8'h99);
        chk("psw set", o_psw, 8'hff);
        c = '{acc_we: 1, acc: 8'h03, cy_we: 1, ac_we: 1, ov_we: 1,
              default: '0};
        pulse(c);
        chk("psw clear", o_psw, 8'h3a);
        v = o_sp;
        c = '0;
        c.sp_push = 1'b1;
        @(posedge i_clk_sys);
        i_core <= c;
        #1;
        chk("push addr", o_stack_addr, v + 8'h01);
        c.sp_push = 1'b0;
        c.sp_pop = 1'b1;
        pulse(c);
        chk("pop", o_sp, v);
    endtask

    // Enable low must freeze a pending load; a reset then clears all.
    task automatic t_freeze();
        c = '0;
        c.acc_we = 1'b1;
        c.acc = 8'h55;
        @(posedge i_clk_sys);
        i_ce   <= 1'b0;
        i_core <= c;
        @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        #1;
        chk("freeze", o_acc, 8'h03);
        @(posedge i_clk_sys);
        i_ce <= 1'b1;
        @(posedge i_clk_sys);
        i_core <= '0;
        #1;
        chk("thaw", o_acc, 8'h55);
        @(posedge i_clk_sys);
        i_nrst <= 1'b0;
        @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        #1;
        chk("reset acc", o_acc, MCSR_RST_BYTE);
        chk("reset ptr", o_active_data_pointer, MCSR_RST_ACTIVE_DATA_POINTER);
        chk("reset page", o_paged_data_access_addr, 16'h0034);
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        idx = '{MCSR_IDX_PAGED_DATA_UPPER_ADDR, MCSR_IDX_SP, MCSR_IDX_DPL0, MCSR_IDX_DPH0,
                MCSR_IDX_SECOND_PTR_LOW, MCSR_IDX_CTRL, MCSR_IDX_DPS, MCSR_IDX_SECOND_PTR_HIGH,
                MCSR_IDX_PSW, MCSR_IDX_ACC, MCSR_IDX_B};
        {i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {i_core, i_ri_val, i_reg_sel, fail_count, checks} = '0;
        i_ce = 1'b1;
        i_pstrb = 4'h1;
        repeat (4) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        t_regs();
        t_ctrl();
        t_addr();
        t_active_data_pointer();
        t_core();
        t_freeze();
        wrap_up();
    end

    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end
endmodule
